// [core/sdr_pkg.sv]
// Constants and types for the SPI diagnosis read-out decoder
package sdr_pkg;
  localparam int          FRAME_BITS  = 16;
  localparam int          CNT_W       = 5;
  localparam logic [4:0]  CNT_FRAME   = 5'h10;
  localparam logic [4:0]  CNT_MAX     = 5'h1f;
  localparam int          CH_PER_GRP  = 8;
  // Control byte nibbles
  localparam logic [3:0]  NIB_LOW     = 4'h0;
  localparam logic [3:0]  NIB_HIGH    = 4'hf;
  localparam logic [3:0]  NIB_READ    = 4'hc;
  localparam logic [3:0]  NIB_ECHO    = 4'ha;
  localparam logic [3:0]  NIB_OR      = 4'h3;
  localparam logic [3:0]  NIB_AND     = 4'hf;
  // Two-bit diagnosis codes per channel
  localparam logic [1:0]  DG_OK       = 2'h3;
  localparam logic [1:0]  DG_OVERLOAD = 2'h2;
  localparam logic [1:0]  DG_OPEN     = 2'h1;
  localparam logic [1:0]  DG_SHORT_GND = 2'h0;
  localparam logic [15:0] WORD_ZERO   = 16'h0000;

  typedef enum logic [2:0] {
    RSP_ZERO    = 3'b000,
    RSP_DIAG_LO = 3'b001,
    RSP_DIAG_HI = 3'b010,
    RSP_RB_LO   = 3'b011,
    RSP_RB_HI   = 3'b100,
    RSP_ECHO    = 3'b101
  } sdr_rsp_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic si;
  } sdr_pins_t;
endpackage

// [core/sdr_decoder.sv]
// SPI slave decoding diagnosis-only, read-back and echo commands
// What this block does
// - Control byte all low requests full diagnosis of channels 1-8, outputs untouched.
// - Next chip-select period shifts out 16-bit diagnosis word of channels 1-8.
// - Control byte LLLL HHHH requests full diagnosis of channels 9-16.
// - Next chip-select period shifts out 16-bit diagnosis of channels 9-16.
// - Control byte HHLL LLLL requests read-back of inputs plus diagnosis, 1-8.
// - Control byte HHLL HHHH requests read-back of inputs plus diagnosis, 9-16.
// - Read-back answer is eight input states plus one diagnosis bit each.
// - Upper nibble HLHL with lower all low or all high selects echo.
// - During next chip-select period serial input loops straight to serial output.
// - Channel code: HH ok, HL overload, LH open load, LL short to ground.
// - Diagnosis of the group read by a full-diagnosis command is cleared at chip-select fall, groups separate; read-back clears nothing.
// - Unknown control byte is rejected; next period returns all zeros.
// - Echo loop lasts one period only; the period after returns zeros.
`timescale 1ns/100ps
module sdr_decoder (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // SPI pins
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        si,
  output logic             so,
  output logic             so_oe_n,
  // Diagnosis and inputs of the switch
  input  wire logic [15:0] diag_lo,
  input  wire logic [15:0] diag_hi,
  input  wire logic [15:0] par_in,
  // Diagnosis register clear strobes
  output logic             diag_clr_lo,
  output logic             diag_clr_hi,
  // Status
  output logic             echo_active,
  output logic             cmd_reject
);

  sdr_pkg::sdr_pins_t                pins_in;
  sdr_pkg::sdr_pins_t                sync1_reg;
  sdr_pkg::sdr_pins_t                sync2_reg;
  sdr_pkg::sdr_pins_t                sync3_reg;
  sdr_pkg::sdr_pins_t                filt_reg;
  sdr_pkg::sdr_pins_t                filt_next;
  sdr_pkg::sdr_pins_t                filt_d_reg;
  sdr_pkg::sdr_rsp_t                 rsp_reg;
  sdr_pkg::sdr_rsp_t                 rsp_next;
  logic [sdr_pkg::FRAME_BITS-1:0]    rx_reg;
  logic [sdr_pkg::FRAME_BITS-1:0]    tx_reg;
  logic [sdr_pkg::FRAME_BITS-1:0]    tx_load;
  logic [sdr_pkg::CNT_W-1:0]         cnt_reg;
  logic [7:0]                        ok_lo;
  logic [7:0]                        ok_hi;
  logic [3:0]                        nib_hi;
  logic [3:0]                        nib_lo;
  logic                              cs_fall;
  logic                              cs_rise;
  logic                              sclk_rise;
  logic                              sclk_fall;
  logic                              frame_ok;
  logic                              lo_all_l;
  logic                              lo_all_h;

  assign pins_in = '{sclk: sclk, cs_n: cs_n, si: si};

  // Three-stage synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0};
      sync2_reg <= '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0};
      sync3_reg <= '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0};
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Accept a level once stages two and three agree
  always_comb begin
    filt_next.sclk = (sync2_reg.sclk == sync3_reg.sclk) ? sync3_reg.sclk : filt_reg.sclk;
    filt_next.cs_n = (sync2_reg.cs_n == sync3_reg.cs_n) ? sync3_reg.cs_n : filt_reg.cs_n;
    filt_next.si   = (sync2_reg.si == sync3_reg.si) ? sync3_reg.si : filt_reg.si;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_reg   <= '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0};
      filt_d_reg <= '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0};
    end else begin
      filt_reg   <= filt_next;
      filt_d_reg <= filt_reg;
    end
  end

  assign cs_fall   = filt_d_reg.cs_n && !filt_reg.cs_n;
  assign cs_rise   = !filt_d_reg.cs_n && filt_reg.cs_n;
  assign sclk_rise = !filt_reg.cs_n && !filt_d_reg.sclk && filt_reg.sclk;
  assign sclk_fall = !filt_reg.cs_n && filt_d_reg.sclk && !filt_reg.sclk;

  // One bit per channel: high means no fault
  always_comb begin
    for (int i = 0; i < sdr_pkg::CH_PER_GRP; i++) begin
      ok_lo[i] = (diag_lo[2*i +: 2] == sdr_pkg::DG_OK);
      ok_hi[i] = (diag_hi[2*i +: 2] == sdr_pkg::DG_OK);
    end
  end

  // Answer word loaded at chip-select fall
  always_comb begin
    unique case (rsp_reg)
      sdr_pkg::RSP_DIAG_LO: tx_load = diag_lo;
      sdr_pkg::RSP_DIAG_HI: tx_load = diag_hi;
      sdr_pkg::RSP_RB_LO:   tx_load = {par_in[7:0], ok_lo};
      sdr_pkg::RSP_RB_HI:   tx_load = {par_in[15:8], ok_hi};
      default:              tx_load = sdr_pkg::WORD_ZERO;
    endcase
  end

  // Receive shift and bit count, MSB first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_reg  <= sdr_pkg::WORD_ZERO;
      cnt_reg <= '0;
    end else if (cs_fall) begin
      rx_reg  <= sdr_pkg::WORD_ZERO;
      cnt_reg <= '0;
    end else if (sclk_rise) begin
      rx_reg  <= {rx_reg[sdr_pkg::FRAME_BITS-2:0], filt_reg.si};
      if (cnt_reg != sdr_pkg::CNT_MAX) begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end

  assign frame_ok = (cnt_reg == sdr_pkg::CNT_FRAME);
  assign nib_hi   = rx_reg[15:12];
  assign nib_lo   = rx_reg[11:8];
  assign lo_all_l = (nib_lo == sdr_pkg::NIB_LOW);
  assign lo_all_h = (nib_lo == sdr_pkg::NIB_HIGH);

  // Decode of the control byte at chip-select rise; data byte ignored
  always_comb begin
    rsp_next = sdr_pkg::RSP_ZERO;
    if (rsp_reg == sdr_pkg::RSP_ECHO) begin
      rsp_next = sdr_pkg::RSP_ZERO;
    end else if (frame_ok && (lo_all_l || lo_all_h)) begin
      if (nib_hi == sdr_pkg::NIB_LOW) begin
        rsp_next = lo_all_l ? sdr_pkg::RSP_DIAG_LO : sdr_pkg::RSP_DIAG_HI;
      end else if (nib_hi == sdr_pkg::NIB_OR || nib_hi == sdr_pkg::NIB_AND) begin
        rsp_next = lo_all_l ? sdr_pkg::RSP_DIAG_LO : sdr_pkg::RSP_DIAG_HI;
      end else if (nib_hi == sdr_pkg::NIB_READ) begin
        rsp_next = lo_all_l ? sdr_pkg::RSP_RB_LO : sdr_pkg::RSP_RB_HI;
      end else if (nib_hi == sdr_pkg::NIB_ECHO) begin
        rsp_next = sdr_pkg::RSP_ECHO;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_reg    <= sdr_pkg::RSP_ZERO;
      cmd_reject <= 1'b0;
    end else if (cs_rise) begin
      rsp_reg    <= rsp_next;
      cmd_reject <= (rsp_reg != sdr_pkg::RSP_ECHO) && (rsp_next == sdr_pkg::RSP_ZERO);
    end
  end

  // Echo loop stays closed only while chip select is active
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      echo_active <= 1'b0;
    end else if (cs_fall) begin
      echo_active <= (rsp_reg == sdr_pkg::RSP_ECHO);
    end else if (cs_rise) begin
      echo_active <= 1'b0;
    end
  end

  // Transmit shift, new bit on each falling clock edge except in the echo period, where so follows si
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_reg <= sdr_pkg::WORD_ZERO;
      so     <= 1'b0;
    end else if (cs_fall) begin
      tx_reg <= tx_load;
      so     <= tx_load[sdr_pkg::FRAME_BITS-1];
    end else if (echo_active) begin
      so     <= filt_reg.si;
    end else if (sclk_fall) begin
      tx_reg <= {tx_reg[sdr_pkg::FRAME_BITS-2:0], 1'b0};
      so     <= tx_reg[sdr_pkg::FRAME_BITS-2];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      so_oe_n <= 1'b1;
    end else begin
      so_oe_n <= filt_reg.cs_n;
    end
  end

  // Clear the group's diagnosis after loading it for a full-diagnosis command, not for read-back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_clr_lo <= 1'b0;
      diag_clr_hi <= 1'b0;
    end else begin
      diag_clr_lo <= cs_fall && (rsp_reg == sdr_pkg::RSP_DIAG_LO);
      diag_clr_hi <= cs_fall && (rsp_reg == sdr_pkg::RSP_DIAG_HI);
    end
  end

  property p_diag_lo;
    @(posedge clk) disable iff (!rst_n)
    cs_fall && rsp_reg == sdr_pkg::RSP_DIAG_LO |=> tx_reg == $past(diag_lo) && so == tx_reg[15];
  endproperty
  a_diag_lo: assert property (p_diag_lo) else $error("low group diagnosis not loaded");

  property p_diag_hi;
    @(posedge clk) disable iff (!rst_n)
    cs_fall && rsp_reg == sdr_pkg::RSP_DIAG_HI |=> tx_reg == $past(diag_hi);
  endproperty
  a_diag_hi: assert property (p_diag_hi) else $error("high group diagnosis not loaded");

  property p_rb_lo;
    @(posedge clk) disable iff (!rst_n)
    cs_fall && rsp_reg == sdr_pkg::RSP_RB_LO |=> tx_reg == {$past(par_in[7:0]), $past(ok_lo)};
  endproperty
  a_rb_lo: assert property (p_rb_lo) else $error("low read-back inputs wrong");

  property p_rb_hi;
    @(posedge clk) disable iff (!rst_n)
    cs_fall && rsp_reg == sdr_pkg::RSP_RB_HI |=> tx_reg == {$past(par_in[15:8]), $past(ok_hi)};
  endproperty
  a_rb_hi: assert property (p_rb_hi) else $error("high read-back word wrong");

  property p_echo_loop;
    @(posedge clk) disable iff (!rst_n)
    echo_active && !cs_rise |=> so == $past(filt_reg.si);
  endproperty
  a_echo_loop: assert property (p_echo_loop) else $error("echo does not follow input");

  property p_echo_once;
    @(posedge clk) disable iff (!rst_n)
    cs_rise && rsp_reg == sdr_pkg::RSP_ECHO |=> rsp_reg == sdr_pkg::RSP_ZERO ##1 !echo_active;
  endproperty
  a_echo_once: assert property (p_echo_once) else $error("echo stayed armed");

  property p_echo_decode;
    @(posedge clk) disable iff (!rst_n)
    cs_rise && frame_ok && nib_hi == sdr_pkg::NIB_ECHO && (lo_all_l || lo_all_h)
      && rsp_reg != sdr_pkg::RSP_ECHO
      |=> rsp_reg == sdr_pkg::RSP_ECHO;
  endproperty
  a_echo_decode: assert property (p_echo_decode) else $error("echo command missed");

  property p_reject;
    @(posedge clk) disable iff (!rst_n)
    cs_rise && !frame_ok |=> rsp_reg == sdr_pkg::RSP_ZERO;
  endproperty
  a_reject: assert property (p_reject) else $error("bad frame not rejected");

  property p_clear;
    @(posedge clk) disable iff (!rst_n)
    cs_fall && rsp_reg == sdr_pkg::RSP_DIAG_HI |=> diag_clr_hi && !diag_clr_lo ##1 !diag_clr_hi;
  endproperty
  a_clear: assert property (p_clear) else $error("diagnosis clear strobe wrong");

endmodule

// [tb/sdr_master.sv]
// SPI master model that clocks frames into the decoder
`timescale 1ns/100ps
module sdr_master (
  // Clock
  input  wire logic clk,
  // SPI pins
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Data changes with sclk low, both lines sampled at the sclk rise
  task automatic frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      si = tx[i];
      wait_clk(10);
      sclk = 1'b1;
      rx = {rx[14:0], so};
      wait_clk(10);
      sclk = 1'b0;
    end
    wait_clk(10);
    cs_n = 1'b1;
    // Released line must not keep its last level
    si = ~si;
    wait_clk(10);
  endtask
endmodule

// [tb/sdr_decoder_test.sv]
// Self-checking bench for the diagnosis read-out decoder
`timescale 1ns/100ps
module sdr_decoder_test;
  logic        clk;
  logic        rst_n;
  logic        sclk;
  logic        cs_n;
  logic        si;
  logic        so;
  logic        so_oe_n;
  logic [15:0] diag_lo;
  logic [15:0] diag_hi;
  logic [15:0] par_in;
  logic        diag_clr_lo;
  logic        diag_clr_hi;
  logic        echo_active;
  logic        cmd_reject;
  logic [15:0] rx;
  int          error_cnt;
  int          n_checks;
  int          clr_lo_cnt;
  int          clr_hi_cnt;
  int          echo_cnt;

  sdr_decoder uut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
    .so_oe_n(so_oe_n), .diag_lo(diag_lo), .diag_hi(diag_hi), .par_in(par_in),
    .diag_clr_lo(diag_clr_lo), .diag_clr_hi(diag_clr_hi), .echo_active(echo_active),
    .cmd_reject(cmd_reject));
  sdr_master master (.clk(clk), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (diag_clr_lo === 1'b1) clr_lo_cnt <= clr_lo_cnt + 1;
    if (diag_clr_hi === 1'b1) clr_hi_cnt <= clr_hi_cnt + 1;
    if (echo_active === 1'b1) echo_cnt <= echo_cnt + 1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [7:0] ok_bits(input logic [15:0] d);
    for (int i = 0; i < 8; i++) begin
      ok_bits[i] = (d[2*i+1 -: 2] === sdr_pkg::DG_OK);
    end
  endfunction

  // Command frame, then a rejected filler frame that carries the answer out
  task automatic send_pair(input logic [7:0] cmd, output int dlo, output int dhi);
    master.frame({cmd, 8'h5a}, 16, rx);
    check(cmd_reject, 1'b0, "reject flag after valid command");
    dlo = clr_lo_cnt;
    dhi = clr_hi_cnt;
    master.frame(16'h7000, 16, rx);
    dlo = clr_lo_cnt - dlo;
    dhi = clr_hi_cnt - dhi;
  endtask

  task automatic diag_test;
    int dlo;
    int dhi;
    send_pair(8'h00, dlo, dhi);
    check(rx, diag_lo, "diagnosis word low group");
    check(dlo, 1, "clear pulses low group");
    check(dhi, 0, "clear pulses high group");
    send_pair(8'h0f, dlo, dhi);
    check(rx, diag_hi, "diagnosis word high group");
    check(dlo, 0, "clear pulses low group");
    check(dhi, 1, "clear pulses high group");
    send_pair(8'h30, dlo, dhi);
    check(rx, diag_lo, "diagnosis word after low group output command");
    check(dlo, 1, "clear pulses after low group output command");
    check(dhi, 0, "no high clear after low group output command");
    send_pair(8'hff, dlo, dhi);
    check(rx, diag_hi, "diagnosis word after high group output command");
    check(dlo, 0, "no low clear after high group output command");
    check(dhi, 1, "clear pulses after high group output command");
  endtask

  task automatic readback_test;
    int dlo;
    int dhi;
    send_pair(8'hc0, dlo, dhi);
    check(rx, {par_in[7:0], ok_bits(diag_lo)}, "read-back low group");
    check(dlo, 0, "no clear on read-back");
    send_pair(8'hcf, dlo, dhi);
    check(rx, {par_in[15:8], ok_bits(diag_hi)}, "read-back high group");
    check(dhi, 0, "no clear on read-back");
  endtask

  task automatic echo_test;
    logic [7:0] codes [2];
    int         ecnt;
    codes = '{8'ha0, 8'haf};
    foreach (codes[k]) begin
      master.frame({codes[k], 8'h33}, 16, rx);
      check(cmd_reject, 1'b0, "reject flag after echo command");
      ecnt = echo_cnt;
      master.frame(16'h3c96, 16, rx);
      check(rx, 16'h3c96, "echoed bits");
      check(echo_cnt > ecnt, 1'b1, "echo loop not closed");
      check(cmd_reject, 1'b0, "frame in echo period rejected");
      ecnt = echo_cnt;
      master.frame(16'h7000, 16, rx);
      check(rx, sdr_pkg::WORD_ZERO, "period after echo");
      check(echo_cnt, ecnt, "echo loop closed twice");
      check(cmd_reject, 1'b1, "filler after echo not rejected");
    end
  endtask

  task automatic reject_test;
    master.frame(16'h7055, 16, rx);
    check(cmd_reject, 1'b1, "unknown command flag");
    master.frame(16'h00ff, 15, rx);
    check(rx, sdr_pkg::WORD_ZERO, "answer to unknown command");
    check(cmd_reject, 1'b1, "short frame flag");
    master.frame(16'h7000, 16, rx);
    check(rx, sdr_pkg::WORD_ZERO, "answer to short frame");
    check(so_oe_n, 1'b1, "output released when idle");
  endtask

  task automatic test_done;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    test_done();
  end

  initial begin
    rst_n   = 1'b0;
    diag_lo = 16'hc6e4;
    diag_hi = 16'h39b1;
    par_in  = 16'ha55a;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    diag_test();
    readback_test();
    echo_test();
    reject_test();
    test_done();
  end
endmodule
